// >>> verilog/arx_pkg.sv
`default_nettype none

package arx_pkg;

   // Reference clock derived from the 20 MHz system clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int REF_PERIOD_NS = 1000;
   localparam int REF_DIV = REF_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [4:0] REF_LAST = 5'(REF_DIV - 1);
   localparam logic [2:0] SLOW_LAST = 3'h7;   // Low speed samples every 8 reference ticks
   localparam logic [3:0] GAP_LAST = 4'h9;    // Gap check every 10 samples
   localparam logic [1:0] GAP_NEED = 2'h3;
   localparam logic [4:0] BIT_MIN = 5'h08;
   localparam logic [4:0] BIT_MAX = 5'h0c;
   localparam logic [4:0] BIT_LAST = 5'h1f;   // Index of the 32nd bit
   localparam logic [5:0] FIFO_DEPTH = 6'h20;
   localparam logic [5:0] FIFO_HALF = 6'h10;

   // Register byte addresses, index 0 is receiver 1, index 1 receiver 2
   localparam logic [1:0][7:0] OFF_CTRL = {8'h24, 8'h10};
   localparam logic [1:0][7:0] OFF_LABEL = {8'h28, 8'h14};
   localparam logic [1:0][7:0] OFF_MATCH_WR = {8'h2c, 8'h18};
   localparam logic [1:0][7:0] OFF_MATCH_RD = {8'hbc, 8'h9c};
   localparam logic [1:0][7:0] OFF_STAT = {8'hb0, 8'h90};
   localparam logic [1:0][7:0] OFF_FIFO = {8'hc0, 8'ha0};
   localparam logic [1:0][7:0] OFF_BOX1 = {8'hc4, 8'ha4};
   localparam logic [1:0][7:0] OFF_BOX2 = {8'hc8, 8'ha8};
   localparam logic [1:0][7:0] OFF_BOX3 = {8'hcc, 8'hac};
   localparam logic [7:0] OFF_FLAGINT = 8'h34;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ARX_GAP, ARX_IDLE, ARX_WORD} arx_phase_e;

   typedef struct packed {
      logic one_band;
      logic zero_band;
      logic null_band;
   } arx_line_s;

   typedef struct packed {
      logic rsvd;
      logic low_speed;
      logic label_filter_enable;
      logic priority_capture_enable;
      logic source_dest_expect_hi;
      logic source_dest_expect_lo;
      logic source_dest_filter_enable;
      logic parity_check_enable;
   } arx_ctrl_s;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } arx_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } arx_axi_rsp_s;

   typedef struct packed {
      arx_line_s sy1;
      arx_line_s sy2;
      arx_line_s sy3;
      arx_line_s lvl;
      logic [2:0] slowdiv;
      logic [9:0] one_sr;
      logic [9:0] zero_sr;
      logic [9:0] null_sr;
      logic cond_prev;
      arx_phase_e phase;
      logic [4:0] since;
      logic [4:0] bitn;
      logic [31:0] word;
      logic [3:0] gapdiv;
      logic [1:0] gapcnt;
      arx_ctrl_s ctrl;
      logic [2:0][7:0] match;
      logic [255:0] label;
      logic [2:0] lptr;
      logic [2:0][23:0] box;
      logic [2:0] rdy;
      logic [31:0][31:0] mem;
      logic [4:0] rp;
      logic [4:0] wp;
      logic [5:0] cnt;
      logic irq;
   } arx_ch_s;

   typedef struct packed {
      logic [4:0] refcnt;
      logic [7:0] flagint;
      logic awv;
      logic [7:0] awa;
      logic wv;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      arx_ch_s [1:0] ch;
   } arx_state_s;

   // Three consecutive ones somewhere in a five-sample window
   function automatic logic arx_run3(input logic [4:0] w);
      arx_run3 = (&w[2:0]) | (&w[3:1]) | (&w[4:2]);
   endfunction : arx_run3

endpackage : arx_pkg

`default_nettype wire

// >>> verilog/arx_rx.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`default_nettype none

// Behaviour
// - Three 10-bit sample registers: One, Zero, Null
// - At most one register shifts a one
// - Bit needs data run, then null run
// - Gap null needs runs in both halves
// - Bit spacing 8 to 12 samples
// - Gap timer checks null every 10/80 reference ticks
// - Next word only after gap count 3
// - Parity pass writes zero into bit 32
// - Parity fail writes one into bit 32
// - Parity off keeps word unchanged
// - Source/destination bits mismatch discards word
// - Matching label captured into priority mailbox
// - Capture disabled leaves mailboxes untouched
// - Match write: bytes for boxes 3,2,1
// - Match values readable back
// - Mailbox holds 24 non-label bits, readable
// - Mailbox ready in status and pins
// - Interrupt pin may pulse on capture
// - Label filter needs table bit set
// - 256-bit table, effective once enabled
// - FIFO stores all four bytes
// - Full FIFO overwrites last location
// - Half flag at sixteen or more words
module arx_rx (
   input wire logic clk,
   input wire logic rst,
   input wire arx_pkg::arx_axi_req_s axi_req,
   output arx_pkg::arx_axi_rsp_s axi_rsp,
   input wire arx_pkg::arx_line_s [1:0] line_in,
   output logic rx1_box1_ready_pin,
   output logic rx1_box2_ready_pin,
   output logic rx1_box3_ready_pin,
   output logic rx2_box1_ready_pin,
   output logic rx2_box2_ready_pin,
   output logic rx2_box3_ready_pin,
   output logic rx1_irq_pin,
   output logic rx2_irq_pin,
   output logic rx1_flag_pin,
   output logic rx2_flag_pin
);

   arx_pkg::arx_state_s s_ff;
   arx_pkg::arx_state_s nxt_s;
   logic [1:0] flag_lvl;

   // Bus handshakes follow the holding registers
   assign axi_rsp.awready = !s_ff.awv;
   assign axi_rsp.wready = !s_ff.wv;
   assign axi_rsp.bvalid = s_ff.bv;
   assign axi_rsp.bresp = s_ff.br;
   assign axi_rsp.arready = !s_ff.rv;
   assign axi_rsp.rvalid = s_ff.rv;
   assign axi_rsp.rdata = s_ff.rd;
   assign axi_rsp.rresp = s_ff.rr;

   // Mailbox ready pins and interrupt pulses
   assign rx1_box1_ready_pin = s_ff.ch[0].rdy[0];
   assign rx1_box2_ready_pin = s_ff.ch[0].rdy[1];
   assign rx1_box3_ready_pin = s_ff.ch[0].rdy[2];
   assign rx2_box1_ready_pin = s_ff.ch[1].rdy[0];
   assign rx2_box2_ready_pin = s_ff.ch[1].rdy[1];
   assign rx2_box3_ready_pin = s_ff.ch[1].rdy[2];
   assign rx1_irq_pin = s_ff.ch[0].irq;
   assign rx2_irq_pin = s_ff.ch[1].irq;
   assign rx1_flag_pin = flag_lvl[0];
   assign rx2_flag_pin = flag_lvl[1];

   // Queue flag pins as selected in the flag/interrupt register
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         unique case (s_ff.flagint[c*4 +: 2])
            2'h0: flag_lvl[c] = (s_ff.ch[c].cnt == 6'h00);
            2'h1: flag_lvl[c] = (s_ff.ch[c].cnt == arx_pkg::FIFO_DEPTH);
            2'h2: flag_lvl[c] = (s_ff.ch[c].cnt >= arx_pkg::FIFO_HALF);
            2'h3: flag_lvl[c] = (s_ff.ch[c].cnt != 6'h00);
         endcase
      end
   end

   // Next-state logic for bus slave and both receive channels
   always_comb begin
      logic ref_tick;
      logic do_wr;
      logic do_rd;
      logic samp;
      logic in_one;
      logic in_zero;
      logic in_null;
      logic cond;
      logic bit_val;
      logic bit_ev;
      logic gap_null;
      logic [4:0] since_inc;
      logic done;
      logic [31:0] fin;
      logic sd_ok;
      logic [2:0] setr;
      logic push;
      logic pop;
      logic [5:0] cnt_ap;
      logic [1:0] isel;
      ref_tick = 1'b0;
      do_wr = 1'b0;
      do_rd = 1'b0;
      samp = 1'b0;
      in_one = 1'b0;
      in_zero = 1'b0;
      in_null = 1'b0;
      cond = 1'b0;
      bit_val = 1'b0;
      bit_ev = 1'b0;
      gap_null = 1'b0;
      since_inc = 5'h00;
      done = 1'b0;
      fin = 32'h0;
      sd_ok = 1'b0;
      setr = 3'h0;
      push = 1'b0;
      pop = 1'b0;
      cnt_ap = 6'h00;
      isel = 2'h0;
      nxt_s = s_ff;

      // 1 MHz reference tick
      ref_tick = (s_ff.refcnt == arx_pkg::REF_LAST);
      nxt_s.refcnt = ref_tick ? 5'h00 : s_ff.refcnt + 5'h01;

      // Write address and data are latched independently
      if (axi_req.awvalid && !s_ff.awv) begin
         nxt_s.awv = 1'b1;
         nxt_s.awa = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_ff.wv) begin
         nxt_s.wv = 1'b1;
         nxt_s.wd = axi_req.wdata;
         nxt_s.ws = axi_req.wstrb;
      end
      do_wr = s_ff.awv && s_ff.wv && !s_ff.bv;
      if (s_ff.bv && axi_req.bready) begin
         nxt_s.bv = 1'b0;
      end
      if (do_wr) begin
         nxt_s.awv = 1'b0;
         nxt_s.wv = 1'b0;
         nxt_s.bv = 1'b1;
         nxt_s.br = arx_pkg::RESP_SLVERR;
      end
      do_rd = axi_req.arvalid && !s_ff.rv;
      if (s_ff.rv && axi_req.rready) begin
         nxt_s.rv = 1'b0;
      end
      if (do_rd) begin
         nxt_s.rv = 1'b1;
         nxt_s.rr = arx_pkg::RESP_SLVERR;
         nxt_s.rd = 32'h0;
      end

      // Flag/interrupt assignment register
      if (do_wr && s_ff.awa == arx_pkg::OFF_FLAGINT) begin
         if (s_ff.ws[0]) begin
            nxt_s.flagint = s_ff.wd[7:0];
         end
         nxt_s.br = arx_pkg::RESP_OKAY;
      end
      if (do_rd && axi_req.araddr == arx_pkg::OFF_FLAGINT) begin
         nxt_s.rd = {24'h0, s_ff.flagint};
         nxt_s.rr = arx_pkg::RESP_OKAY;
      end

      for (int c = 0; c < 2; c++) begin
         // Three-stage line synchroniser, level moves once stages two and three agree
         nxt_s.ch[c].sy1 = line_in[c];
         nxt_s.ch[c].sy2 = s_ff.ch[c].sy1;
         nxt_s.ch[c].sy3 = s_ff.ch[c].sy2;
         if (s_ff.ch[c].sy2 == s_ff.ch[c].sy3) begin
            nxt_s.ch[c].lvl = s_ff.ch[c].sy3;
         end

         // Sample strobe: every reference tick, or every eighth at low speed
         samp = ref_tick && (!s_ff.ch[c].ctrl.low_speed || s_ff.ch[c].slowdiv == arx_pkg::SLOW_LAST);
         if (ref_tick) begin
            nxt_s.ch[c].slowdiv = s_ff.ch[c].slowdiv + 3'h1;
         end

         // Mutually exclusive state samples, all zero between bands
         in_one = s_ff.ch[c].lvl.one_band && !s_ff.ch[c].lvl.zero_band;
         in_zero = s_ff.ch[c].lvl.zero_band && !s_ff.ch[c].lvl.one_band;
         in_null = s_ff.ch[c].lvl.null_band && !in_one && !in_zero && !s_ff.ch[c].lvl.zero_band;
         if (samp) begin
            nxt_s.ch[c].one_sr = {s_ff.ch[c].one_sr[8:0], in_one};
            nxt_s.ch[c].zero_sr = {s_ff.ch[c].zero_sr[8:0], in_zero};
            nxt_s.ch[c].null_sr = {s_ff.ch[c].null_sr[8:0], in_null};
         end

         // Older half holds the data pulse, newer half the trailing null
         cond = (arx_pkg::arx_run3(s_ff.ch[c].one_sr[9:5]) || arx_pkg::arx_run3(s_ff.ch[c].zero_sr[9:5]))
                && arx_pkg::arx_run3(s_ff.ch[c].null_sr[4:0]);
         bit_val = arx_pkg::arx_run3(s_ff.ch[c].one_sr[9:5]);
         bit_ev = samp && cond && !s_ff.ch[c].cond_prev;
         if (samp) begin
            nxt_s.ch[c].cond_prev = cond;
         end
         gap_null = arx_pkg::arx_run3(s_ff.ch[c].null_sr[9:5]) && arx_pkg::arx_run3(s_ff.ch[c].null_sr[4:0]);
         since_inc = (s_ff.ch[c].since == 5'h1f) ? 5'h1f : s_ff.ch[c].since + 5'h01;
         if (samp) begin
            nxt_s.ch[c].since = since_inc;
         end

         // Word reception sequence
         done = 1'b0;
         fin = s_ff.ch[c].word;
         unique case (s_ff.ch[c].phase)
            arx_pkg::ARX_GAP: begin
               if (samp) begin
                  nxt_s.ch[c].gapdiv = s_ff.ch[c].gapdiv + 4'h1;
                  if (s_ff.ch[c].gapdiv == arx_pkg::GAP_LAST) begin
                     nxt_s.ch[c].gapdiv = 4'h0;
                     if (gap_null) begin
                        nxt_s.ch[c].gapcnt = s_ff.ch[c].gapcnt + 2'h1;
                        if (s_ff.ch[c].gapcnt + 2'h1 == arx_pkg::GAP_NEED) begin
                           nxt_s.ch[c].phase = arx_pkg::ARX_IDLE;
                        end
                     end
                  end
               end
            end
            arx_pkg::ARX_IDLE: begin
               if (bit_ev) begin
                  nxt_s.ch[c].word = {31'h0, bit_val};
                  nxt_s.ch[c].bitn = 5'h01;
                  nxt_s.ch[c].since = 5'h00;
                  nxt_s.ch[c].phase = arx_pkg::ARX_WORD;
               end
            end
            arx_pkg::ARX_WORD: begin
               if (bit_ev && since_inc >= arx_pkg::BIT_MIN && since_inc <= arx_pkg::BIT_MAX) begin
                  nxt_s.ch[c].word[s_ff.ch[c].bitn] = bit_val;
                  nxt_s.ch[c].bitn = s_ff.ch[c].bitn + 5'h01;
                  nxt_s.ch[c].since = 5'h00;
                  if (s_ff.ch[c].bitn == arx_pkg::BIT_LAST) begin
                     done = 1'b1;
                     fin[arx_pkg::BIT_LAST] = bit_val;
                     nxt_s.ch[c].phase = arx_pkg::ARX_GAP;
                     nxt_s.ch[c].gapdiv = 4'h0;
                     nxt_s.ch[c].gapcnt = 2'h0;
                  end
               end else if (samp && (bit_ev || since_inc > arx_pkg::BIT_MAX)) begin
                  nxt_s.ch[c].phase = arx_pkg::ARX_GAP;
                  nxt_s.ch[c].gapdiv = 4'h0;
                  nxt_s.ch[c].gapcnt = 2'h0;
               end
            end
            default: begin
               nxt_s.ch[c].phase = arx_pkg::ARX_GAP;
            end
         endcase

         // Parity replaces bit 32 only when checking is on
         if (s_ff.ch[c].ctrl.parity_check_enable) begin
            fin[31] = !(^fin);
         end

         // Source/destination check on bits 9 and 10
         sd_ok = !s_ff.ch[c].ctrl.source_dest_filter_enable ||
                 (fin[8] == s_ff.ch[c].ctrl.source_dest_expect_lo &&
                  fin[9] == s_ff.ch[c].ctrl.source_dest_expect_hi);

         // Register writes
         if (do_wr && s_ff.awa == arx_pkg::OFF_CTRL[c]) begin
            if (s_ff.ws[0]) begin
               nxt_s.ch[c].ctrl = arx_pkg::arx_ctrl_s'(s_ff.wd[7:0]);
            end
            nxt_s.br = arx_pkg::RESP_OKAY;
         end
         if (do_wr && s_ff.awa == arx_pkg::OFF_MATCH_WR[c]) begin
            if (s_ff.ws[0]) begin
               nxt_s.ch[c].match[2] = s_ff.wd[7:0];
            end
            if (s_ff.ws[1]) begin
               nxt_s.ch[c].match[1] = s_ff.wd[15:8];
            end
            if (s_ff.ws[2]) begin
               nxt_s.ch[c].match[0] = s_ff.wd[23:16];
            end
            nxt_s.br = arx_pkg::RESP_OKAY;
         end
         if (do_wr && s_ff.awa == arx_pkg::OFF_LABEL[c]) begin
            nxt_s.ch[c].label[{s_ff.ch[c].lptr, 5'h00} +: 32] = s_ff.wd;
            nxt_s.ch[c].lptr = s_ff.ch[c].lptr + 3'h1;
            nxt_s.br = arx_pkg::RESP_OKAY;
         end

         // Register reads and their side effects
         pop = 1'b0;
         if (do_rd) begin
            if (axi_req.araddr == arx_pkg::OFF_CTRL[c]) begin
               nxt_s.rd = {24'h0, s_ff.ch[c].ctrl};
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_MATCH_RD[c]) begin
               nxt_s.rd = {8'h00, s_ff.ch[c].match[0], s_ff.ch[c].match[1], s_ff.ch[c].match[2]};
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_STAT[c]) begin
               nxt_s.rd = {26'h0, s_ff.ch[c].rdy,
                           s_ff.ch[c].cnt == arx_pkg::FIFO_DEPTH,
                           s_ff.ch[c].cnt >= arx_pkg::FIFO_HALF,
                           s_ff.ch[c].cnt == 6'h00};
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_FIFO[c]) begin
               pop = (s_ff.ch[c].cnt != 6'h00);
               nxt_s.rd = pop ? s_ff.ch[c].mem[s_ff.ch[c].rp] : 32'h0;
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_BOX1[c]) begin
               nxt_s.rd = {8'h00, s_ff.ch[c].box[0]};
               nxt_s.ch[c].rdy[0] = 1'b0;
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_BOX2[c]) begin
               nxt_s.rd = {8'h00, s_ff.ch[c].box[1]};
               nxt_s.ch[c].rdy[1] = 1'b0;
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
            if (axi_req.araddr == arx_pkg::OFF_BOX3[c]) begin
               nxt_s.rd = {8'h00, s_ff.ch[c].box[2]};
               nxt_s.ch[c].rdy[2] = 1'b0;
               nxt_s.rr = arx_pkg::RESP_OKAY;
            end
         end

         // Priority capture; a capture in the read cycle keeps ready set
         setr = 3'h0;
         for (int k = 0; k < 3; k++) begin
            if (done && sd_ok && s_ff.ch[c].ctrl.priority_capture_enable && fin[7:0] == s_ff.ch[c].match[k]) begin
               nxt_s.ch[c].box[k] = fin[31:8];
               nxt_s.ch[c].rdy[k] = 1'b1;
               setr[k] = 1'b1;
            end
         end

         // Receive queue with label look-up filter
         push = done && sd_ok && (!s_ff.ch[c].ctrl.label_filter_enable || s_ff.ch[c].label[fin[7:0]]);
         cnt_ap = s_ff.ch[c].cnt - {5'h00, pop};
         if (pop) begin
            nxt_s.ch[c].rp = s_ff.ch[c].rp + 5'h01;
         end
         if (push && cnt_ap == arx_pkg::FIFO_DEPTH) begin
            nxt_s.ch[c].mem[s_ff.ch[c].wp - 5'h01] = fin;
         end else if (push) begin
            nxt_s.ch[c].mem[s_ff.ch[c].wp] = fin;
            nxt_s.ch[c].wp = s_ff.ch[c].wp + 5'h01;
         end
         nxt_s.ch[c].cnt = cnt_ap + {5'h00, push && cnt_ap != arx_pkg::FIFO_DEPTH};

         // Interrupt pulse source select
         isel = s_ff.flagint[c*4+2 +: 2];
         nxt_s.ch[c].irq = (isel == 2'h0) ? (push || (|setr)) : setr[isel - 2'h1];
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

endmodule : arx_rx

`default_nettype wire

// >>> sim/arx_monitor.sv
`default_nettype none

module arx_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire arx_pkg::arx_axi_req_s axi_req,
   input wire arx_pkg::arx_axi_rsp_s axi_rsp,
   input wire arx_pkg::arx_line_s [1:0] line_in,
   input wire logic rx1_box2_ready_pin,
   input wire logic rx1_irq_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Address and data taken together, and a read request taken
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence s_rd_take;
      axi_req.arvalid && axi_rsp.arready;
   endsequence

   // Bus handshake timing and holding of answers
   a_write_answer: assert property (s_wr_take |-> ##2 axi_rsp.bvalid)
      else $error("write response missing");
   a_bresp_held: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_rd_take |=> axi_rsp.rvalid)
      else $error("read data missing");
   a_rdata_held: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data dropped");
   a_read_blocks: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read taken while data pending");
   a_unmapped_err: assert property (s_rd_take ##0 axi_req.araddr == 8'h00
      |=> axi_rsp.rresp == arx_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   a_ro_write_err: assert property (s_wr_take ##0 axi_req.awaddr == arx_pkg::OFF_STAT[0]
      |-> ##2 axi_rsp.bresp == arx_pkg::RESP_SLVERR)
      else $error("status write not refused");

   // Line side events
   a_irq_pulse: assert property (rx1_irq_pin |=> !rx1_irq_pin)
      else $error("interrupt longer than one cycle");
   a_irq_after_null: assert property (rx1_irq_pin |-> $past(line_in[0].null_band, 10) && $past(line_in[0].null_band, 30))
      else $error("word done without trailing null");
   a_box_read_clear: assert property (s_rd_take ##0 axi_req.araddr == arx_pkg::OFF_BOX2[0] |-> ##[1:2] !rx1_box2_ready_pin)
      else $error("mailbox ready not cleared");
endmodule : arx_monitor

`default_nettype wire

// >>> sim/arx_line_model.sv
`default_nettype none

module arx_line_model (
   input wire logic clk,
   output arx_pkg::arx_line_s line
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus sits at null
   initial line = '{1'b0, 1'b0, 1'b1};

   // Hold one line state for n sample periods
   task automatic hold(input logic o, input logic z, input int n);
      line <= '{o, z, !o && !z};
      repeat (n * arx_pkg::REF_DIV) @(posedge clk);
   endtask : hold

   // Leading null gap, then 32 bits, bit 1 first, each half data half null
   task automatic send(input logic [31:0] w, input int half, input int gap);
      @(posedge clk);
      hold(1'b0, 1'b0, gap);
      for (int i = 0; i < 32; i++) begin
         hold(w[i], !w[i], half);
         hold(1'b0, 1'b0, half);
      end
   endtask : send
endmodule : arx_line_model

`default_nettype wire

// >>> sim/arx_rx_tb.sv
`default_nettype none

module arx_rx_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk;
   logic rst;
   arx_pkg::arx_axi_req_s req;
   arx_pkg::arx_axi_rsp_s rsp;
   arx_pkg::arx_line_s [1:0] line;
   logic [2:0] box1;
   logic [2:0] box2;
   logic [1:0] irq;
   logic [1:0] flag;
   logic [1:0][31:0] m = {32'h00aabbcc, 32'h00315577};
   logic [31:0] d;
   logic [1:0] r;
   int n_errors = 0;
   int num_checks = 0;
   int irq1 = 0;
   int irq2 = 0;

   arx_rx dut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .line_in(line),
      .rx1_box1_ready_pin(box1[0]), .rx1_box2_ready_pin(box1[1]), .rx1_box3_ready_pin(box1[2]),
      .rx2_box1_ready_pin(box2[0]), .rx2_box2_ready_pin(box2[1]), .rx2_box3_ready_pin(box2[2]),
      .rx1_irq_pin(irq[0]), .rx2_irq_pin(irq[1]), .rx1_flag_pin(flag[0]), .rx2_flag_pin(flag[1]));
   arx_line_model p0 (.clk(clk), .line(line[0]));
   arx_line_model p1 (.clk(clk), .line(line[1]));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Count interrupt pulses
   always @(posedge clk) begin
      if (irq[0] === 1'b1) irq1 <= irq1 + 1;
      if (irq[1] === 1'b1) irq2 <= irq2 + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // One bus transfer; each channel released once taken, answer awaited
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic [1:0] resp);
      @(posedge clk);
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= 1'b0;
      req.arvalid <= !wr;
      req.rready <= 1'b0;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= wd;
      for (int n = 0; n < 200; n++) begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.arready) req.arvalid <= 1'b0;
         if ((wr && rsp.bvalid && req.bready) || (!wr && rsp.rvalid && req.rready)) begin
            resp = wr ? rsp.bresp : rsp.rresp;
            rdat = rsp.rdata;
            req.bready <= 1'b0;
            req.rready <= 1'b0;
            return;
         end
         // Ready follows valid by one edge, so the answer must stand meanwhile
         req.bready <= wr && rsp.bvalid;
         req.rready <= !wr && rsp.rvalid;
      end
      n_errors++;
      $display("ERROR %0t: bus timeout", $time);
      print_verdict();
   endtask : xfer

   task automatic wrc(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd, d, r);
      chk({30'h0, r}, {30'h0, arx_pkg::RESP_OKAY});
   endtask : wrc

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, arx_pkg::RESP_OKAY});
   endtask : rdc

   task automatic endt(input string s);
      $display("test %s done", s);
   endtask : endt

   initial begin
      req = '0;
      req.wstrb = 4'hf;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values, refused accesses, match registers
      chk({31'h0, flag[0]}, 32'h1);
      xfer(1'b0, 8'h00, 32'h0, d, r);
      chk({30'h0, r}, {30'h0, arx_pkg::RESP_SLVERR});
      chk(d, 32'h0);
      xfer(1'b1, arx_pkg::OFF_STAT[0], 32'h0, d, r);
      chk({30'h0, r}, {30'h0, arx_pkg::RESP_SLVERR});
      for (int c = 0; c < 2; c++) begin
         rdc(arx_pkg::OFF_CTRL[c], 32'h0);
         rdc(arx_pkg::OFF_STAT[c], 32'h1);
         rdc(arx_pkg::OFF_MATCH_RD[c], 32'h0);
         wrc(arx_pkg::OFF_MATCH_WR[c], m[c]);
         rdc(arx_pkg::OFF_MATCH_RD[c], m[c]);
      end
      endt("registers");
      // Plain words on both receivers, capture off
      fork
         p0.send(32'h12345631, 5, 40);
         p1.send(32'h87654321, 5, 40);
      join
      chk(irq1, 32'd1);
      chk(irq2, 32'd1);
      chk({31'h0, flag[0]}, 32'h0);
      rdc(arx_pkg::OFF_FIFO[0], 32'h12345631);
      rdc(arx_pkg::OFF_FIFO[1], 32'h87654321);
      rdc(arx_pkg::OFF_STAT[0], 32'h1);
      chk({26'h0, box2, box1}, 32'h0);
      endt("plain");
      // Parity at both spacing limits
      wrc(arx_pkg::OFF_CTRL[0], 32'h1);
      p0.send(32'h00000003, 4, 40);
      p0.send(32'h80000107, 6, 40);
      rdc(arx_pkg::OFF_FIFO[0], 32'h80000003);
      rdc(arx_pkg::OFF_FIFO[0], 32'h00000107);
      endt("parity");
      // Too slow bits, then a word after a short gap
      p0.send(32'h0000f0f0, 7, 40);
      p0.send(32'h00000001, 5, 40);
      p0.send(32'h00000002, 5, 15);
      rdc(arx_pkg::OFF_FIFO[0], 32'h00000001);
      rdc(arx_pkg::OFF_STAT[0], 32'h1);
      chk(irq1, 32'd4);
      endt("timing");
      // Source/destination, label table and priority capture
      for (int k = 0; k < 8; k++) begin
         wrc(arx_pkg::OFF_LABEL[0], (k == 2) ? 32'h00200000 : 32'h0);
      end
      wrc(arx_pkg::OFF_FLAGINT, 32'h8);
      wrc(arx_pkg::OFF_CTRL[0], 32'h36);
      p0.send(32'h00000255, 5, 40);
      p0.send(32'h00000166, 5, 40);
      rdc(arx_pkg::OFF_STAT[0], 32'h1);
      chk(irq1, 32'd4);
      p0.send(32'habcde155, 5, 40);
      chk(irq1, 32'd5);
      chk({29'h0, box1}, 32'h2);
      rdc(arx_pkg::OFF_STAT[0], 32'h10);
      wrc(arx_pkg::OFF_FLAGINT, 32'h3b);
      chk({30'h0, flag}, 32'h1);
      rdc(arx_pkg::OFF_BOX2[0], 32'h00abcde1);
      rdc(arx_pkg::OFF_FIFO[0], 32'habcde155);
      chk({26'h0, box2, box1}, 32'h0);
      endt("filters");
      print_verdict();
   end
endmodule : arx_rx_tb

bind arx_rx arx_monitor u_mon (.clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .line_in(line_in), .rx1_box2_ready_pin(rx1_box2_ready_pin), .rx1_irq_pin(rx1_irq_pin));

`default_nettype wire
